/* verif/dfm_properties.sv */
/*
  Port-level assertions for the deviation fault monitor.
  Assumes binding to dfm_top with one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module dfm_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        running,
  input wire logic [1:0]  ctrl_mode,
  input wire logic        pos_loop_en,
  input wire logic [15:0] freq_cmd,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] est_speed,
  input wire logic [15:0] crane_speed,
  input wire logic [31:0] pos_cmd,
  input wire logic [31:0] pos_cur,
  input wire logic        speed_dev_fail,
  input wire logic        pos_dev_fail,
  input wire logic        irq
);
  logic [15:0] src;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The compared speed follows the control mode, so a cause check must pick the same source.
  always_comb src = (ctrl_mode == 2'h0) ? motor_speed : (ctrl_mode == 2'h1) ? est_speed : crane_speed;
  spd_latch_a: assert property (speed_dev_fail |=> speed_dev_fail) else $error("speed failure dropped");
  pos_latch_a: assert property (pos_dev_fail |=> pos_dev_fail) else $error("position failure dropped");
  spd_cause_a: assert property ($rose(speed_dev_fail) |-> $past(running) && $past(freq_cmd != src))
    else $error("speed failure without cause");
  pos_cause_a: assert property ($rose(pos_dev_fail) |-> $past(pos_loop_en) && $past(pos_cmd != pos_cur))
    else $error("position failure without cause");
  irq_src_a: assert property (irq |-> speed_dev_fail || pos_dev_fail) else $error("interrupt without failure");
  apb_ready_a: assert property (psel && penable |-> pready) else $error("access stalled");
  apb_err_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
  bad_addr_a: assert property (psel && penable && !pwrite && paddr > 8'h28 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  cover property ($rose(speed_dev_fail));
  cover property ($rose(pos_dev_fail));
  cover property ($rose(irq));
endmodule
bind dfm_top dfm_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .running(running), .ctrl_mode(ctrl_mode),
  .pos_loop_en(pos_loop_en), .freq_cmd(freq_cmd), .motor_speed(motor_speed), .est_speed(est_speed),
  .crane_speed(crane_speed), .pos_cmd(pos_cmd), .pos_cur(pos_cur), .speed_dev_fail(speed_dev_fail),
  .pos_dev_fail(pos_dev_fail), .irq(irq));

/* verif/tb_deviation_fault_monitor.sv */
/*
  Self-checking bench for the deviation fault monitor.
  Assumes a 4-cycle control tick and zero-wait APB reads queued as expectations.
*/
`timescale 1ns/1ps
module tb_deviation_fault_monitor;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pos_cmd = 32'h0, pos_cur = 32'h0;
  logic        pready, pslverr, speed_dev_fail, pos_dev_fail, irq;
  logic        running = 1'b0, pos_feed = 1'b0, pos_loop_en = 1'b0, dmeter_fault = 1'b0, dmeter_alarm = 1'b0;
  logic [1:0]  ctrl_mode = 2'h0;
  logic [15:0] freq_cmd = 16'h0, motor_speed = 16'h0, est_speed = 16'h0, crane_speed = 16'h0, f;
  logic [32:0] expq [$];
  int          miscompares = 0, n_compared = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  dfm_top #(.TICK_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .running(running), .pos_feed(pos_feed), .ctrl_mode(ctrl_mode), .pos_loop_en(pos_loop_en),
    .dmeter_fault(dmeter_fault), .dmeter_alarm(dmeter_alarm), .freq_cmd(freq_cmd), .motor_speed(motor_speed),
    .est_speed(est_speed), .crane_speed(crane_speed), .pos_cmd(pos_cmd), .pos_cur(pos_cur),
    .speed_dev_fail(speed_dev_fail), .pos_dev_fail(pos_dev_fail), .irq(irq));
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Only the source picked by the mode deviates, so a wrong source choice shows as a missed failure.
  task automatic spd(input logic [1:0] m, input logic pf, input logic dm, input logic [31:0] sel,
                     input logic [15:0] d, input logic [31:0] thr, input logic ef);
    // Stop the drive first, so stale inputs from the last case cannot arm a half-written setup.
    running <= 1'b0;
    rst();
    apb(1'b1, dfm_pkg::ADDR_SELECT, sel, 33'h0);
    apb(1'b1, dfm_pkg::ADDR_SPD_THR, thr, 33'h0);
    apb(1'b1, dfm_pkg::ADDR_SPD_TIME, 32'h2, 33'h0);
    f = 16'($urandom_range(1000));
    ctrl_mode <= m; pos_feed <= pf; dmeter_fault <= dm; dmeter_alarm <= dm; running <= 1'b1; freq_cmd <= f;
    motor_speed <= (m == 2'h0) ? f + d : f;
    est_speed <= (m == 2'h1) ? f - d : f;
    crane_speed <= m[1] ? f + d : f;
    repeat (24) @(posedge pclk);
    chk("speed_dev_fail", {32'h0, ef}, {32'h0, speed_dev_fail});
    $display("speed case mode %0d done", m);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk("read data", expq.pop_front(), {pslverr, prdata});
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hD087));
    rst();
    apb(1'b0, dfm_pkg::ADDR_SELECT, 32'h0, 33'h0);
    apb(1'b0, dfm_pkg::ADDR_SPD_THR, 32'h0, {17'h0, dfm_pkg::SPD_THR_RST});
    apb(1'b0, dfm_pkg::ADDR_POS_DIST, 32'h0, {17'h0, dfm_pkg::POS_DIST_RST});
    apb(1'b0, dfm_pkg::ADDR_IRQ_MASK, 32'h0, 33'h0);
    apb(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
    $display("reset values done");
    spd(2'h0, 1'b1, 1'b0, 32'h4, 16'hA, 32'hA, 1'b0);
    spd(2'h0, 1'b1, 1'b0, 32'h8, 16'hB, 32'hA, 1'b0);
    spd(2'h2, 1'b0, 1'b0, 32'h4, 16'hB, 32'hA, 1'b0);
    spd(2'h3, 1'b1, 1'b1, 32'h4, 16'hB, 32'hA, 1'b0);
    spd(2'h0, 1'b1, 1'b0, 32'h4, 16'hB, 32'h270F, 1'b0);
    for (int m = 0; m < 4; m++) spd(2'(m), 1'b1, 1'b0, 32'h4, 16'hB, 32'hA, 1'b1);
    crane_speed <= f;
    repeat (24) @(posedge pclk);
    chk("latched speed fail", 33'h1, {32'h0, speed_dev_fail});
    apb(1'b1, dfm_pkg::ADDR_IRQ_MASK, 32'h1, 33'h0);
    @(posedge pclk);
    chk("irq", 33'h1, {32'h0, irq});
    apb(1'b0, dfm_pkg::ADDR_IRQ_STAT, 32'h0, 33'h1);
    @(posedge pclk);
    chk("irq after clear", 33'h0, {32'h0, irq});
    $display("latch and interrupt done");
    spd(2'h0, 1'b1, 1'b0, 32'h4, 16'h0, 32'hA, 1'b0);
    // Two exceeding ticks, one quiet tick, two more: short of three in a row.
    motor_speed <= f + 16'hB;
    repeat (8) @(posedge pclk);
    motor_speed <= f;
    repeat (4) @(posedge pclk);
    motor_speed <= f + 16'hB;
    repeat (8) @(posedge pclk);
    motor_speed <= f;
    @(posedge pclk);
    chk("interrupted deviation", 33'h0, {32'h0, speed_dev_fail});
    $display("timer restart done");
    rst();
    apb(1'b1, dfm_pkg::ADDR_SELECT, 32'h8, 33'h0);
    apb(1'b1, dfm_pkg::ADDR_POS_DIST, 32'h64, 33'h0);
    apb(1'b1, dfm_pkg::ADDR_POS_TIME, 32'h1, 33'h0);
    pos_cmd <= $urandom_range(100000);
    pos_loop_en <= 1'b1;
    @(posedge pclk);
    pos_cur <= pos_cmd - 32'h64;
    repeat (24) @(posedge pclk);
    chk("pos fail at limit", 33'h0, {32'h0, pos_dev_fail});
    apb(1'b0, dfm_pkg::ADDR_LIVE, 32'h0, 33'h2);
    pos_loop_en <= 1'b0;
    pos_cur <= pos_cmd + 32'h65;
    repeat (24) @(posedge pclk);
    chk("pos fail loop off", 33'h0, {32'h0, pos_dev_fail});
    pos_loop_en <= 1'b1;
    repeat (24) @(posedge pclk);
    chk("pos fail", 33'h1, {32'h0, pos_dev_fail});
    apb(1'b0, dfm_pkg::ADDR_FAIL, 32'h0, 33'h2);
    $display("position case done");
    // Let the monitor compare the last read before the run ends.
    @(posedge pclk);
    wrap_up();
  end
endmodule

/* verilog/dfm_persist.sv */
/*
  One deviation channel: magnitude compare, persistence timer and failure latch.
  Assumes operands and settings are steady between ticks of the control rate.
*/
`timescale 1ns/1ps
module dfm_persist (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        arm,
  input  wire logic [31:0] val_a,
  input  wire logic [31:0] val_b,
  input  wire logic [15:0] limit,
  input  wire logic [15:0] hold_time,
  output logic             exceed,
  output logic [15:0]      count,
  output logic             fail
);

  dfm_pkg::dfm_persist_t q;
  dfm_pkg::dfm_persist_t d;
  logic signed [32:0]    diff;
  logic [32:0]           mag;

  // A 33-bit difference keeps the sign even for full-scale operands.
  assign diff   = $signed({val_a[31], val_a}) - $signed({val_b[31], val_b});
  assign mag    = diff[32] ? 33'(-diff) : 33'(diff);
  assign exceed = mag > {17'h00000, limit};
  assign count  = q.cnt;
  assign fail   = q.fail;

  always_comb begin
    d = q;
    if (tick && !q.fail) begin
      if (arm && exceed) begin
        if (q.cnt >= hold_time) begin
          d.fail = 1'b1;
        end else begin
          d.cnt = 16'(q.cnt + 16'h0001);
        end
      end else begin
        d.cnt = 16'h0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* verilog/dfm_pkg.sv */
/*
  Constants, register map and types shared by the deviation fault monitor.
  Assumes a 40 MHz pclk and an APB master with 32-bit data.
*/
// How it works
// - The speed deviation check runs only while select bit 2 is one, otherwise it never fails.
// - Speed deviation is compared against its threshold and must persist for its time setting.
// - In closed-loop vector control the command is compared with the measured motor speed.
// - In sensorless vector control the command is compared with the estimated speed.
// - In flux vector or V/F control the command is compared with the crane speed.
// - The speed check is armed only while running, threshold not 9999, and the mode is allowed for the feed.
// - A declared speed or position failure stays latched until reset.
// - The position deviation check runs only while select bit 3 is one.
// - Position failure is declared when the position error exceeds the distance for the time setting.
// - The position check is armed only with the position loop on and the distance not 9999.
package dfm_pkg;

  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned TICK_NS    = 1_000_000;
  localparam int unsigned TICK_CYC   = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;

  localparam logic [7:0]  ADDR_SELECT   = 8'h00;
  localparam logic [7:0]  ADDR_SPD_THR  = 8'h04;
  localparam logic [7:0]  ADDR_SPD_TIME = 8'h08;
  localparam logic [7:0]  ADDR_POS_DIST = 8'h0C;
  localparam logic [7:0]  ADDR_POS_TIME = 8'h10;
  localparam logic [7:0]  ADDR_FAIL     = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0]  ADDR_SPD_CNT  = 8'h20;
  localparam logic [7:0]  ADDR_POS_CNT  = 8'h24;
  localparam logic [7:0]  ADDR_LIVE     = 8'h28;

  localparam int unsigned SEL_SPEED_BIT = 2;
  localparam int unsigned SEL_POS_BIT   = 3;
  localparam int unsigned FAIL_SPD_BIT  = 0;
  localparam int unsigned FAIL_POS_BIT  = 1;
  localparam int unsigned NCHAN         = 2;

  localparam logic [15:0] DISABLE_VALUE = 16'h270F;

  localparam logic [15:0] SELECT_RST    = 16'h0000;
  localparam logic [15:0] SPD_THR_RST   = 16'h270F;
  localparam logic [15:0] SPD_TIME_RST  = 16'h0000;
  localparam logic [15:0] POS_DIST_RST  = 16'h270F;
  localparam logic [15:0] POS_TIME_RST  = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;

  typedef enum logic [1:0] {
    MODE_VECTOR     = 2'h0,
    MODE_SENSORLESS = 2'h1,
    MODE_FLUX       = 2'h2,
    MODE_VF         = 2'h3
  } dfm_mode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        fail;
  } dfm_persist_t;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic        tick;
    logic [15:0] select;
    logic [15:0] spd_thr;
    logic [15:0] spd_time;
    logic [15:0] pos_dist;
    logic [15:0] pos_time;
    logic [1:0]  fail_prev;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
  } dfm_state_t;

endpackage

/* verilog/dfm_top.sv */
/*
  Deviation fault monitor: speed and position deviation supervision with an APB register file.
  Assumes drive status and measured values come from logic on pclk, so they are not resynchronised.
*/
`timescale 1ns/1ps
module dfm_top #(
  parameter int unsigned TICK_CYCLES = dfm_pkg::TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        running,
  input  wire logic        pos_feed,
  input  wire logic [1:0]  ctrl_mode,
  input  wire logic        pos_loop_en,
  input  wire logic        dmeter_fault,
  input  wire logic        dmeter_alarm,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] motor_speed,
  input  wire logic [15:0] est_speed,
  input  wire logic [15:0] crane_speed,
  input  wire logic [31:0] pos_cmd,
  input  wire logic [31:0] pos_cur,
  output logic             speed_dev_fail,
  output logic             pos_dev_fail,
  output logic             irq
);

  dfm_pkg::dfm_state_t q;
  dfm_pkg::dfm_state_t d;

  dfm_pkg::dfm_mode_t  mode;
  logic [15:0]         spd_meas;
  logic                mode_ok;
  logic                spd_arm;
  logic                pos_arm;
  logic [1:0]          ch_arm;
  logic [31:0]         ch_a     [dfm_pkg::NCHAN];
  logic [31:0]         ch_b     [dfm_pkg::NCHAN];
  logic [15:0]         ch_limit [dfm_pkg::NCHAN];
  logic [15:0]         ch_time  [dfm_pkg::NCHAN];
  logic [15:0]         ch_count [dfm_pkg::NCHAN];
  logic [1:0]          ch_exceed;
  logic [1:0]          ch_fail;
  logic [1:0]          fail_rise;
  logic                wr_acc;
  logic                rd_setup;
  logic                rd_acc;
  logic                addr_ok;
  logic [31:0]         rd_word;

  assign mode = dfm_pkg::dfm_mode_t'(ctrl_mode);

  // The speed source follows the control mode in use.
  always_comb begin
    case (mode)
      dfm_pkg::MODE_VECTOR: begin
        spd_meas = motor_speed;
      end
      dfm_pkg::MODE_SENSORLESS: begin
        spd_meas = est_speed;
      end
      default: begin
        spd_meas = crane_speed;
      end
    endcase
  end

  // Flux vector and V/F rely on the crane speed, so a distance meter problem
  // makes that source untrustworthy and the check must stand down.
  always_comb begin
    mode_ok = (mode == dfm_pkg::MODE_VECTOR) || (mode == dfm_pkg::MODE_SENSORLESS);
    if (pos_feed && !dmeter_fault && !dmeter_alarm) begin
      mode_ok = 1'b1;
    end
  end

  assign spd_arm = q.select[dfm_pkg::SEL_SPEED_BIT] && running && mode_ok &&
                   (q.spd_thr != dfm_pkg::DISABLE_VALUE);
  assign pos_arm = q.select[dfm_pkg::SEL_POS_BIT] && pos_loop_en &&
                   (q.pos_dist != dfm_pkg::DISABLE_VALUE);

  assign ch_arm   = {pos_arm, spd_arm};
  assign ch_a[0]  = {{16{freq_cmd[15]}}, freq_cmd};
  assign ch_b[0]  = {{16{spd_meas[15]}}, spd_meas};
  assign ch_a[1]  = pos_cmd;
  assign ch_b[1]  = pos_cur;
  assign ch_limit[0] = q.spd_thr;
  assign ch_limit[1] = q.pos_dist;
  assign ch_time[0]  = q.spd_time;
  assign ch_time[1]  = q.pos_time;

  // Both supervised quantities share the same persistence and latch behaviour.
  genvar gi;
  generate
    for (gi = 0; gi < dfm_pkg::NCHAN; gi = gi + 1) begin : g_chan
      dfm_persist u_persist (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (q.tick),
        .arm       (ch_arm[gi]),
        .val_a     (ch_a[gi]),
        .val_b     (ch_b[gi]),
        .limit     (ch_limit[gi]),
        .hold_time (ch_time[gi]),
        .exceed    (ch_exceed[gi]),
        .count     (ch_count[gi]),
        .fail      (ch_fail[gi])
      );
    end
  endgenerate

  assign speed_dev_fail = ch_fail[dfm_pkg::FAIL_SPD_BIT];
  assign pos_dev_fail   = ch_fail[dfm_pkg::FAIL_POS_BIT];
  assign fail_rise      = ch_fail & ~q.fail_prev;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_acc   = psel && penable && !pwrite;

  // Address decode and read mux, used for both the error answer and the read data.
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h00000000;
    if (paddr == dfm_pkg::ADDR_SELECT) begin
      rd_word = {16'h0000, q.select};
    end else if (paddr == dfm_pkg::ADDR_SPD_THR) begin
      rd_word = {16'h0000, q.spd_thr};
    end else if (paddr == dfm_pkg::ADDR_SPD_TIME) begin
      rd_word = {16'h0000, q.spd_time};
    end else if (paddr == dfm_pkg::ADDR_POS_DIST) begin
      rd_word = {16'h0000, q.pos_dist};
    end else if (paddr == dfm_pkg::ADDR_POS_TIME) begin
      rd_word = {16'h0000, q.pos_time};
    end else if (paddr == dfm_pkg::ADDR_FAIL) begin
      rd_word = {30'h00000000, ch_fail};
    end else if (paddr == dfm_pkg::ADDR_IRQ_STAT) begin
      rd_word = {30'h00000000, q.irq_stat};
    end else if (paddr == dfm_pkg::ADDR_IRQ_MASK) begin
      rd_word = {30'h00000000, q.irq_mask};
    end else if (paddr == dfm_pkg::ADDR_SPD_CNT) begin
      rd_word = {16'h0000, ch_count[0]};
    end else if (paddr == dfm_pkg::ADDR_POS_CNT) begin
      rd_word = {16'h0000, ch_count[1]};
    end else if (paddr == dfm_pkg::ADDR_LIVE) begin
      rd_word = {28'h0000000, ch_exceed, ch_arm};
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_comb begin
    d = q;

    // Control tick divider; every check advances only on this pulse.
    d.tick = 1'b0;
    if (q.tick_cnt >= TICK_CYCLES - 1) begin
      d.tick_cnt = 32'h00000000;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h00000001;
    end

    d.fail_prev = ch_fail;

    // Read data is captured in the setup phase so it comes from a flop
    // and the slave can still answer with no wait state.
    if (rd_setup) begin
      d.prdata = rd_word;
    end

    if (wr_acc) begin
      if (paddr == dfm_pkg::ADDR_SELECT) begin
        d.select = pwdata[15:0];
      end else if (paddr == dfm_pkg::ADDR_SPD_THR) begin
        d.spd_thr = pwdata[15:0];
      end else if (paddr == dfm_pkg::ADDR_SPD_TIME) begin
        d.spd_time = pwdata[15:0];
      end else if (paddr == dfm_pkg::ADDR_POS_DIST) begin
        d.pos_dist = pwdata[15:0];
      end else if (paddr == dfm_pkg::ADDR_POS_TIME) begin
        d.pos_time = pwdata[15:0];
      end else if (paddr == dfm_pkg::ADDR_IRQ_MASK) begin
        d.irq_mask = pwdata[1:0];
      end
    end

    // A read of the status clears it, but a failure arriving in the access
    // cycle is kept; one arriving in the setup cycle is cleared unread.
    if (rd_acc && (paddr == dfm_pkg::ADDR_IRQ_STAT)) begin
      d.irq_stat = 2'h0;
    end
    d.irq_stat = d.irq_stat | fail_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.tick_cnt  <= 32'h00000000;
      q.tick      <= 1'b0;
      q.select    <= dfm_pkg::SELECT_RST;
      q.spd_thr   <= dfm_pkg::SPD_THR_RST;
      q.spd_time  <= dfm_pkg::SPD_TIME_RST;
      q.pos_dist  <= dfm_pkg::POS_DIST_RST;
      q.pos_time  <= dfm_pkg::POS_TIME_RST;
      q.fail_prev <= 2'h0;
      q.irq_stat  <= 2'h0;
      q.irq_mask  <= dfm_pkg::IRQ_MASK_RST;
      q.prdata    <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign irq     = |(q.irq_stat & q.irq_mask);

endmodule
